// >>> hdl/rxev_regs.v
// Receiver event flags, masks, routing and channel status registers
// What this block does
// - Pass-through select routes input pin to output
// - Receiver select picks internal receiver input pin
// - Flags stick until the flag register read or their enable bit cleared
// - Reading flag register clears all flags but those with a new event that cycle
// - Disabled flags read zero, no interrupt
// - Bit 7 sets on lock loss
// - Bit 5 sets on new subcode block
// - Bit 4 sets on status buffer update
// - Bit 3 sets on user buffer update
// - Bit 1 sets on conversion overrange
// - Bit 0 sets on receiver error
// - Enable register gates flags and interrupt
// - Two mode registers give trigger code
// - Rising, falling or level trigger behaviour
// - Only polarity field sets pin level
// - Polarity: high, low, open-drain low
// - Receiver error gated by error enables
// - Lock method field resets to 01
// - Buffer select: status or user data
// - Access width: one or two bytes
// - Subframe select picks A or B
// - Status bits 7:4 report aux width
// - Status bit 3 reports block format
`timescale 1ns/10ps
`default_nettype none
`include "rxev_map.vh"
module rxev_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] receiver_input_pin,
    output wire passthru_output_pin,
    output wire receiver_in,
    input wire lock_lost,
    input wire subcode_new,
    input wire status_buffer_new,
    input wire user_buffer_new,
    input wire conversion_overrange,
    input wire [6:0] receiver_error_cond,
    input wire [3:0] aux_width_a,
    input wire [3:0] aux_width_b,
    input wire block_format_a,
    input wire block_format_b,
    input wire [2:0] stream_flags_a,
    input wire [2:0] stream_flags_b,
    output reg [1:0] lock_method,
    output reg buffer_content_select,
    output reg buffer_access_width,
    output reg subframe_select,
    output reg [7:0] receiver_error_enable,
    output reg irq_out,
    output reg irq_oe
);
    reg [2:0] passthru_select;
    reg [2:0] receiver_input_select;
    reg [7:0] event_flags;
    reg [7:0] event_enable;
    reg [7:0] event_trigger_high;
    reg [7:0] event_trigger_low;
    reg [1:0] irq_polarity;
    reg [7:0] next_flags;
    reg [7:0] rd_val;
    reg hit_valid;
    wire [7:0] cond;
    wire [7:0] hit;
    wire [7:0] live;
    wire [7:0] idx;
    wire acc;
    wire wr;
    wire rd;
    wire irq_any;
    wire wr_enable;
    wire wr_trig_hi;
    wire wr_trig_lo;
    wire wr_buf_ctrl;
    wire wr_route;
    wire wr_pin_ctrl;
    wire wr_err_enable;
    wire rd_flags;

    // Word index from byte address
    function [7:0] reg_index;
        input [11:0] a;
        begin
            reg_index = a[`RXEV_ADDR_W-1:2];
        end
    endfunction

    // Strobe for one register index in the access phase
    function reg_strobe;
        input active;
        input valid;
        input [7:0] at;
        input [7:0] want;
        begin
            reg_strobe = active & valid & (at == want);
        end
    endfunction

    // Address decode
    assign idx = reg_index(paddr);
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = acc & ~hit_valid;

    // Access strobes per register
    assign wr_enable = reg_strobe(wr, hit_valid, idx, `RXEV_IDX_ENABLE);
    assign wr_trig_hi = reg_strobe(wr, hit_valid, idx, `RXEV_IDX_TRIG_HI);
    assign wr_trig_lo = reg_strobe(wr, hit_valid, idx, `RXEV_IDX_TRIG_LO);
    assign wr_buf_ctrl = reg_strobe(wr, hit_valid, idx, `RXEV_IDX_BUF_CTRL);
    assign wr_route = reg_strobe(wr, hit_valid, idx, `RXEV_IDX_ROUTE);
    assign wr_pin_ctrl = reg_strobe(wr, hit_valid, idx, `RXEV_IDX_PIN_CTRL);
    assign wr_err_enable = reg_strobe(wr, hit_valid, idx, `RXEV_IDX_ERR_ENABLE);
    assign rd_flags = reg_strobe(rd, hit_valid, idx, `RXEV_IDX_FLAGS);

    // Mapped index check

    always @* begin
        case (idx)
            `RXEV_IDX_FLAGS, `RXEV_IDX_ENABLE, `RXEV_IDX_TRIG_HI, `RXEV_IDX_TRIG_LO,
            `RXEV_IDX_BUF_CTRL, `RXEV_IDX_STREAM_STAT, `RXEV_IDX_ROUTE,
            `RXEV_IDX_PIN_CTRL, `RXEV_IDX_ERR_ENABLE: hit_valid = (paddr[11:`RXEV_ADDR_W] == 2'b00);
            default: hit_valid = 1'b0;
        endcase
    end

    // Pass-through routing
    rxev_input_mux u_pass (
        .pins(receiver_input_pin),
        .sel(passthru_select),
        .out(passthru_output_pin)
    );

    // Internal receiver routing
    rxev_input_mux u_recv (
        .pins(receiver_input_pin),
        .sel(receiver_input_select),
        .out(receiver_in)
    );

    // Source conditions at their flag positions
    assign cond[`RXEV_BIT_UNLOCK] = lock_lost;
    assign cond[`RXEV_BIT_RSVD_HI] = 1'b0;
    assign cond[`RXEV_BIT_SUBCODE] = subcode_new;
    assign cond[`RXEV_BIT_STATBUF] = status_buffer_new;
    assign cond[`RXEV_BIT_USERBUF] = user_buffer_new;
    assign cond[`RXEV_BIT_RSVD_LO] = 1'b0;
    assign cond[`RXEV_BIT_OVER] = conversion_overrange;
    assign cond[`RXEV_BIT_RXERR] = |(receiver_error_cond & receiver_error_enable[6:0]);

    // Trigger mode detection
    rxev_event_detect u_det (
        .pclk(pclk),
        .presetn(presetn),
        .cond(cond),
        .trig_hi(event_trigger_high),
        .trig_lo(event_trigger_low),
        .hit(hit)
    );

    assign live = hit & event_enable & `RXEV_SRC_MASK;

    // Read clears, a new event in the same cycle wins
    always @* begin
        next_flags = event_flags;
        if (rd_flags) begin
            next_flags = `RXEV_ZERO8;
        end
        next_flags = (next_flags | live) & event_enable;
    end

    // Read data mux
    always @* begin
        case (idx)
            `RXEV_IDX_FLAGS: rd_val = event_flags & event_enable;
            `RXEV_IDX_ENABLE: rd_val = event_enable;
            `RXEV_IDX_TRIG_HI: rd_val = event_trigger_high;
            `RXEV_IDX_TRIG_LO: rd_val = event_trigger_low;
            `RXEV_IDX_BUF_CTRL: rd_val = {lock_method, 3'b000, buffer_content_select,
                buffer_access_width, subframe_select};
            `RXEV_IDX_STREAM_STAT: rd_val = subframe_select ?
                {aux_width_b, block_format_b, stream_flags_b} :
                {aux_width_a, block_format_a, stream_flags_a};
            `RXEV_IDX_ROUTE: rd_val = {1'b0, passthru_select, 1'b0, receiver_input_select};
            `RXEV_IDX_PIN_CTRL: rd_val = {4'h0, irq_polarity, 2'b00};
            `RXEV_IDX_ERR_ENABLE: rd_val = receiver_error_enable & `RXEV_ERR_MASK;
            default: rd_val = `RXEV_ZERO8;
        endcase
    end

    // Sticky event flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_flags <= `RXEV_ZERO8;
        end else begin
            event_flags <= next_flags;
        end
    end

    // Read data, held until the next mapped read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `RXEV_PRDATA_RESET;
        end else if (rd && hit_valid) begin
            prdata <= {`RXEV_PRDATA_PAD, rd_val};
        end
    end

    // Event enable mask
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_enable <= `RXEV_ZERO8;
        end else if (wr_enable) begin
            event_enable <= pwdata[`RXEV_BYTE_HI:`RXEV_BYTE_LO] & `RXEV_SRC_MASK;
        end
    end

    // Trigger mode, upper code bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_trigger_high <= `RXEV_ZERO8;
        end else if (wr_trig_hi) begin
            event_trigger_high <= pwdata[`RXEV_BYTE_HI:`RXEV_BYTE_LO] & `RXEV_SRC_MASK;
        end
    end

    // Trigger mode, lower code bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_trigger_low <= `RXEV_ZERO8;
        end else if (wr_trig_lo) begin
            event_trigger_low <= pwdata[`RXEV_BYTE_HI:`RXEV_BYTE_LO] & `RXEV_SRC_MASK;
        end
    end

    // Lock method and buffer controls
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_method <= `RXEV_LOCK_RESET;
            buffer_content_select <= 1'b0;
            buffer_access_width <= 1'b0;
            subframe_select <= 1'b0;
        end else if (wr_buf_ctrl) begin
            lock_method <= pwdata[`RXEV_LOCK_MSB:`RXEV_LOCK_LSB];
            buffer_content_select <= pwdata[`RXEV_BUFFER_CONTENT_SELECT_BIT];
            buffer_access_width <= pwdata[`RXEV_CAM_BIT];
            subframe_select <= pwdata[`RXEV_CHS_BIT];
        end
    end

    // Input route selects
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            passthru_select <= `RXEV_SEL_RESET;
            receiver_input_select <= `RXEV_SEL_RESET;
        end else if (wr_route) begin
            passthru_select <= pwdata[`RXEV_PASS_MSB:`RXEV_PASS_LSB];
            receiver_input_select <= pwdata[`RXEV_RECV_MSB:`RXEV_RECV_LSB];
        end
    end

    // Interrupt pin polarity
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_polarity <= `RXEV_POL_HIGH;
        end else if (wr_pin_ctrl) begin
            irq_polarity <= pwdata[`RXEV_PINPOL_MSB:`RXEV_PINPOL_LSB];
        end
    end

    // Receiver error enables
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receiver_error_enable <= `RXEV_ZERO8;
        end else if (wr_err_enable) begin
            receiver_error_enable <= pwdata[`RXEV_BYTE_HI:`RXEV_BYTE_LO] & `RXEV_ERR_MASK;
        end
    end

    // Any enabled triggered source, polarity applied after the OR
    assign irq_any = |(live | (event_flags & event_enable));

    always @* begin
        case (irq_polarity)
            `RXEV_POL_HIGH: begin
                irq_out = irq_any;
                irq_oe = 1'b1;
            end
            `RXEV_POL_LOW: begin
                irq_out = ~irq_any;
                irq_oe = 1'b1;
            end
            `RXEV_POL_OD: begin
                irq_out = 1'b0;
                irq_oe = irq_any;
            end
            default: begin
                irq_out = 1'b0;
                irq_oe = 1'b0;
            end
        endcase
    end
endmodule // rxev_regs
`default_nettype wire

// >>> hdl/rxev_map.vh
// Register map and field constants for the receiver event and status block
`ifndef RXEV_MAP_VH
`define RXEV_MAP_VH
`define RXEV_IDX_FLAGS 8'h20
`define RXEV_IDX_ENABLE 8'h21
`define RXEV_IDX_TRIG_HI 8'h22
`define RXEV_IDX_TRIG_LO 8'h23
`define RXEV_IDX_BUF_CTRL 8'h24
`define RXEV_IDX_STREAM_STAT 8'h25
`define RXEV_IDX_ROUTE 8'h1F
`define RXEV_IDX_PIN_CTRL 8'h1E
`define RXEV_IDX_ERR_ENABLE 8'h27
`define RXEV_ADDR_W 10
`define RXEV_SRC_MASK 8'hBB
`define RXEV_ERR_MASK 8'h7F
`define RXEV_BIT_UNLOCK 7
`define RXEV_BIT_SUBCODE 5
`define RXEV_BIT_STATBUF 4
`define RXEV_BIT_USERBUF 3
`define RXEV_BIT_OVER 1
`define RXEV_BIT_RXERR 0
`define RXEV_TRIG_RISE 2'b00
`define RXEV_TRIG_FALL 2'b01
`define RXEV_TRIG_LEVEL 2'b10
`define RXEV_POL_HIGH 2'b00
`define RXEV_POL_LOW 2'b01
`define RXEV_POL_OD 2'b10
`define RXEV_LOCK_RESET 2'b01
`define RXEV_AUX_MAX 4'h8
`define RXEV_ZERO8 8'h00
`define RXEV_BIT_RSVD_HI 6
`define RXEV_BIT_RSVD_LO 2
`define RXEV_BYTE_HI 7
`define RXEV_BYTE_LO 0
`define RXEV_LOCK_MSB 7
`define RXEV_LOCK_LSB 6
`define RXEV_BUFFER_CONTENT_SELECT_BIT 2
`define RXEV_CAM_BIT 1
`define RXEV_CHS_BIT 0
`define RXEV_PASS_MSB 6
`define RXEV_PASS_LSB 4
`define RXEV_RECV_MSB 2
`define RXEV_RECV_LSB 0
`define RXEV_PINPOL_MSB 3
`define RXEV_PINPOL_LSB 2
`define RXEV_SEL_RESET 3'h0
`define RXEV_PRDATA_RESET 32'h0000_0000
`define RXEV_PRDATA_PAD 24'h000000
`endif

// >>> hdl/rxev_input_mux.v
// Eight-to-one selector for a receiver input pin
`timescale 1ns/10ps
`default_nettype none
module rxev_input_mux (
    input wire [7:0] pins,
    input wire [2:0] sel,
    output wire out
);
    assign out = pins[sel];
endmodule // rxev_input_mux
`default_nettype wire

// >>> hdl/rxev_event_detect.v
// Per-source trigger detection by rising, falling or level mode
`timescale 1ns/10ps
`default_nettype none
`include "rxev_map.vh"
module rxev_event_detect (
    input wire pclk,
    input wire presetn,
    input wire [7:0] cond,
    input wire [7:0] trig_hi,
    input wire [7:0] trig_lo,
    output reg [7:0] hit
);
    reg [7:0] cond_q;
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_q <= `RXEV_ZERO8;
        end else begin
            cond_q <= cond;
        end
    end
    // Edge or level per source
    always @* begin
        hit = `RXEV_ZERO8;
        for (i = 0; i < 8; i = i + 1) begin
            case ({trig_hi[i], trig_lo[i]})
                `RXEV_TRIG_RISE: hit[i] = cond[i] & ~cond_q[i];
                `RXEV_TRIG_FALL: hit[i] = ~cond[i] & cond_q[i];
                `RXEV_TRIG_LEVEL: hit[i] = cond[i];
                default: hit[i] = 1'b0;
            endcase
        end
    end
endmodule // rxev_event_detect
`default_nettype wire

// >>> dv/rxev_regs_monitor.sv
// Checker bound to the receiver event and status registers
`timescale 1ns/10ps
`default_nettype none
module rxev_regs_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire [7:0] receiver_input_pin,
    input wire passthru_output_pin,
    input wire receiver_in,
    input wire lock_lost,
    input wire subcode_new,
    input wire status_buffer_new,
    input wire user_buffer_new,
    input wire conversion_overrange,
    input wire [6:0] receiver_error_cond,
    input wire [3:0] aux_width_a,
    input wire [3:0] aux_width_b,
    input wire block_format_a,
    input wire block_format_b,
    input wire [1:0] lock_method,
    input wire buffer_content_select,
    input wire buffer_access_width,
    input wire subframe_select
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wr_route = acc && pwrite && paddr == 12'h07C;
    wire wr_buf = acc && pwrite && paddr == 12'h090;
    wire rd_flag = acc && !pwrite && paddr == 12'h080;
    wire rd_stat = acc && !pwrite && paddr == 12'h094;
    wire quiet = ~|{lock_lost, subcode_new, status_buffer_new, user_buffer_new, conversion_overrange, receiver_error_cond};
    reg [5:0] route;
    // Shadow of both route selects
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            route <= 6'h00;
        else if (wr_route)
            route <= {pwdata[6:4], pwdata[2:0]};
    end
    sequence calm_read;
        quiet [*3] ##0 rd_flag;
    endsequence
    sequence calm_reread;
        quiet [*2] ##1 (quiet && rd_flag);
    endsequence
    chk_pass_route: assert property (passthru_output_pin == receiver_input_pin[route[5:3]])
        else $error("passthru pin wrong");
    chk_recv_route: assert property (receiver_in == receiver_input_pin[route[2:0]])
        else $error("receiver input wrong");
    chk_flag_clear: assert property (calm_read ##1 calm_reread |=> prdata == 32'h0)
        else $error("flags not cleared");
    chk_lock_reset: assert property ($rose(presetn) |-> lock_method == 2'b01)
        else $error("lock method reset wrong");
    chk_lock_write: assert property (wr_buf |=> lock_method == $past(pwdata[7:6]))
        else $error("lock method wrong");
    chk_content_sel: assert property (wr_buf |=> buffer_content_select == $past(pwdata[2]))
        else $error("content select wrong");
    chk_access_width: assert property (wr_buf |=> buffer_access_width == $past(pwdata[1]))
        else $error("access width wrong");
    chk_subframe_sel: assert property (wr_buf |=> subframe_select == $past(pwdata[0]))
        else $error("subframe select wrong");
    chk_status_read: assert property (rd_stat |=> prdata[7:3] == ($past(subframe_select) ?
        {$past(aux_width_b), $past(block_format_b)} : {$past(aux_width_a), $past(block_format_a)}))
        else $error("stream status wrong");
endmodule // rxev_regs_chk
bind rxev_regs rxev_regs_chk chk (.*);
`default_nettype wire

// >>> dv/receiver_event_and_status_regs_bench.sv
// Self-checking bench for the receiver event and status registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module receiver_event_and_status_regs_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, d;
    logic [7:0] pins = 8'h00, cnd = 8'h00, sa = 8'h8D, sb = 8'h32;
    wire [31:0] prdata;
    wire pready, pslverr, pto, rxin, cont, wid, sub, irq, oe;
    wire [1:0] lm;
    wire [7:0] een;
    int fails = 0, n_checks = 0, cyc = 0;
    int srcs[6] = '{7, 5, 4, 3, 1, 0};
    rxev_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receiver_input_pin(pins), .passthru_output_pin(pto), .receiver_in(rxin), .lock_lost(cnd[7]),
        .subcode_new(cnd[5]), .status_buffer_new(cnd[4]), .user_buffer_new(cnd[3]),
        .conversion_overrange(cnd[1]), .receiver_error_cond({6'h00, cnd[0]}), .aux_width_a(sa[7:4]),
        .aux_width_b(sb[7:4]), .block_format_a(sa[3]), .block_format_b(sb[3]), .stream_flags_a(sa[2:0]),
        .stream_flags_b(sb[2:0]), .lock_method(lm), .buffer_content_select(cont), .buffer_access_width(wid),
        .subframe_select(sub), .receiver_error_enable(een), .irq_out(irq), .irq_oe(oe));
    initial begin
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude;
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer; read data is taken the cycle after access
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        d = prdata;
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), {24'h0, e}, d)
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        wt(16);
        presetn <= 1'b1;
        rc(12'h080, 8'h00);
        rc(12'h084, 8'h00);
        rc(12'h088, 8'h00);
        rc(12'h08C, 8'h00);
        rc(12'h090, 8'h40);
        rc(12'h07C, 8'h00);
        rc(12'h094, 8'h8D);
        `CHK("mapped", 1'b0, err)
        xfer(1'b0, 12'h0A0, 32'h0);
        `CHK("unmapped", 1'b1, err)
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, 12'h07C, {25'h0, i[2:0], 1'b0, 3'(7 - i)});
            pins <= 8'h01 << i;
            wt(1);
            `CHK("passthru", 1'b1, pto)
            `CHK("rx input", 1'b0, rxin)
            pins <= ~(8'h01 << i);
            wt(1);
            `CHK("passthru", 1'b0, pto)
            `CHK("rx input", 1'b1, rxin)
        end
        xfer(1'b1, 12'h09C, 32'h7F);
        `CHK("err enable", 8'h7F, een)
        xfer(1'b1, 12'h084, 32'hBB);
        foreach (srcs[k]) begin
            cnd <= 8'h01 << srcs[k];
            wt(2);
            cnd <= 8'h00;
            wt(2);
            `CHK("irq", 1'b1, irq)
            rc(12'h080, 8'h01 << srcs[k]);
            rc(12'h080, 8'h00);
            `CHK("irq idle", 1'b0, irq)
        end
        xfer(1'b1, 12'h09C, 32'h00);
        cnd <= 8'h01;
        wt(2);
        cnd <= 8'h00;
        `CHK("irq masked", 1'b0, irq)
        rc(12'h080, 8'h00);
        xfer(1'b1, 12'h084, 32'h00);
        cnd <= 8'hBB;
        wt(2);
        `CHK("irq masked", 1'b0, irq)
        cnd <= 8'h00;
        rc(12'h080, 8'h00);
        xfer(1'b1, 12'h084, 32'hBB);
        xfer(1'b1, 12'h09C, 32'h7F);
        xfer(1'b1, 12'h08C, 32'hBB);
        cnd <= 8'hBB;
        wt(3);
        rc(12'h080, 8'h00);
        cnd <= 8'h00;
        wt(2);
        rc(12'h080, 8'hBB);
        xfer(1'b1, 12'h08C, 32'h00);
        xfer(1'b1, 12'h088, 32'hBB);
        cnd <= 8'h02;
        wt(2);
        rc(12'h080, 8'h02);
        rc(12'h080, 8'h02);
        for (int p = 0; p < 3; p++) begin
            xfer(1'b1, 12'h078, p << 2);
            wt(1);
            `CHK("irq level", p == 0, irq)
            `CHK("irq drive", 1'b1, oe)
        end
        cnd <= 8'h00;
        wt(2);
        xfer(1'b0, 12'h080, 32'h0);
        `CHK("od idle", 1'b0, oe)
        xfer(1'b1, 12'h078, 32'h04);
        wt(1);
        `CHK("low idle", 1'b1, irq)
        xfer(1'b1, 12'h078, 32'h0C);
        wt(1);
        `CHK("no drive", 1'b0, oe)
        xfer(1'b1, 12'h08C, 32'hBB);
        cnd <= 8'hBB;
        wt(2);
        cnd <= 8'h00;
        wt(2);
        rc(12'h080, 8'h00);
        xfer(1'b1, 12'h090, 32'h87);
        wt(1);
        `CHK("ctrl outs", 5'h17, {lm, cont, wid, sub})
        rc(12'h090, 8'h87);
        rc(12'h094, 8'h32);
        conclude;
    end
endmodule // receiver_event_and_status_regs_bench
`default_nettype wire
